// File: core/oscsw_pkg.sv
// Package of register map, field layout, reset values and codes for the oscillator switch
package oscsw_pkg;
  // Byte addresses of the word-wide registers on the bus
  localparam logic [7:0]  ADR_OSC_CONTROL   = 8'h00;
  localparam logic [7:0]  ADR_CLOCK_DIVISOR = 8'h04;
  localparam logic [7:0]  ADR_PLL_FBD       = 8'h08;
  localparam logic [7:0]  ADR_TRIM          = 8'h0c;
  localparam logic [7:0]  ADR_AUX_CTRL      = 8'h10;
  localparam logic [7:0]  ADR_UNLOCK        = 8'h14;
  // Unlock keys, values arbitrary
  localparam logic [15:0] UNLOCK_KEY1       = 16'h5a5a;
  localparam logic [15:0] UNLOCK_KEY2       = 16'ha5a5;
  // Oscillator control field positions
  localparam int CUR_LSB = 12;
  localparam int REQ_LSB = 8;
  localparam int LOCK_BIT = 5;
  localparam int CF_BIT = 3;
  localparam int SECEN_BIT = 1;
  localparam int SWREQ_BIT = 0;
  // Clock divisor field positions
  localparam int ROI_BIT = 15;
  localparam int DOZE_LSB = 12;
  localparam int CORE_SLOWDOWN_ENABLE_BIT = 11;
  localparam int FAST_RC_POSTSCALER_LSB = 8;
  localparam int POST_LSB = 6;
  localparam int PRE_LSB = 0;
  // Auxiliary control field positions
  localparam int AUX_DIVIDER_SOURCE_SEL_BIT = 13;
  localparam int AOSC_LSB = 11;
  localparam int APST_LSB = 8;
  localparam int ASRC_BIT = 7;
  // Reset values
  localparam logic [15:0] CLOCK_DIVISOR_RST = 16'h3040;
  localparam logic [8:0]  PLL_FBD_RST       = 9'h030;
  localparam logic [9:0]  FBD_OFFSET        = 10'h002;
  // Source encodings
  localparam logic [2:0] SRC_FRC      = 3'h0;
  localparam logic [2:0] SRC_FRC_PLL  = 3'h1;
  localparam logic [2:0] SRC_PRI      = 3'h2;
  localparam logic [2:0] SRC_PRI_PLL  = 3'h3;
  localparam logic [2:0] SRC_SEC      = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER_INTERNAL_OSC     = 3'h5;
  localparam logic [2:0] SRC_FRC_D16  = 3'h6;
  localparam logic [2:0] SRC_FRC_DN   = 3'h7;
  // Oscillator enable vector positions
  localparam int OSC_FRC = 0;
  localparam int OSC_PRI = 1;
  localparam int OSC_SEC = 2;
  localparam int OSC_LOW_POWER_INTERNAL_OSC = 3;
  localparam int OSC_PLL = 4;
  localparam logic [1:0] PRI_SUB_EXT = 2'h0;
  localparam logic [2:0] APST_DIV1 = 3'h7;
  localparam logic [2:0] APST_DIV256 = 3'h0;
  localparam logic [3:0] AUX_LOG2_256 = 4'h8;
  // New-clock cycles to wait before the switch
  localparam logic [3:0] SETTLE_CYCLES = 4'ha;
  typedef enum logic [3:0] {
    SW_IDLE  = 4'h1,
    SW_CHECK = 4'h2,
    SW_WAIT  = 4'h4,
    SW_COUNT = 4'h8
  } oscsw_state_t;
endpackage

// File: core/oscsw_top.sv
// Oscillator control registers and hardware clock-switch sequencer behind classic Wishbone
// How it works
// - Current source read-only, requested source writable
// - Lock bit shows PLL locked status
// - Secondary enable bit turns secondary oscillator on
// - Switch request stays set until switch done
// - Control register writes need unlock sequence
// - Wake bit makes interrupts clear slow-core enable
// - Slow-down field gives power-of-two core ratios
// - Slow-core enable off forces ratio one
// - Fast RC postscaler selects eight doubling divisors
// - VCO divider codes two, four, eight
// - Trim field is signed frequency offset
// - Auxiliary mode selects external, crystal, off
// - Auxiliary divider one to 256
// - Auxiliary reference and divider source selects
// - Switching disabled holds request low, boot source
// - Equal sources abort switch, clear request
// - Valid switch clears lock and failure flags
// - Start new oscillator, await crystal and lock
// - Wait ten new clocks, then switch
// - Stop old source except kept oscillators
// - Feedback multiplier equals field plus two
`timescale 1ns/1ps
module oscsw_top (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        CE,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        SWITCHING_ENABLE_CONFIG,
  input  wire logic [2:0]  POWER_ON_SOURCE_CONFIG,
  input  wire logic [1:0]  PRIMARY_SUBMODE_CONFIG,
  input  wire logic        WDT_OR_MONITOR_EN,
  input  wire logic        PLL_LOCKED,
  input  wire logic        CRYSTAL_STARTUP_DONE,
  input  wire logic        NEW_CLK_TICK,
  input  wire logic        CLOCK_FAIL_EVENT,
  input  wire logic        IRQ,
  output logic      [4:0]  OSC_ENABLE,
  output logic      [2:0]  CURRENT_SOURCE_SEL,
  output logic             SWITCH_NOW,
  output logic      [2:0]  CORE_RATIO_LOG2,
  output logic      [2:0]  FAST_RC_POSTSCALER,
  output logic      [1:0]  VCO_OUTPUT_DIVIDER,
  output logic      [4:0]  PHASE_DETECTOR_INPUT_DIVIDER,
  output logic      [9:0]  VCO_MULTIPLIER,
  output logic      [5:0]  FAST_OSC_TRIM,
  output logic      [1:0]  AUX_OSC_MODE,
  output logic      [3:0]  AUX_DIVIDE_LOG2,
  output logic             AUX_REFERENCE_SEL,
  output logic             AUX_DIVIDER_SOURCE_SEL
);

  typedef struct packed {
    logic                 ack;
    logic                 key1_seen;
    logic                 armed;
    logic                 boot_done;
    logic [2:0]           cur_src;
    logic [2:0]           req_src;
    logic                 sw_req;
    logic                 lock;
    logic                 clk_fail;
    logic                 sec_en;
    logic                 wake_full_speed_on_irq;
    logic [2:0]           doze;
    logic                 core_slowdown_enable;
    logic [2:0]           frc_post;
    logic [1:0]           vco_post;
    logic [4:0]           pre_div;
    logic [8:0]           fbd;
    logic [5:0]           trim;
    logic                 aux_src;
    logic [1:0]           aux_mode;
    logic [2:0]           aux_div;
    logic                 aux_ref;
    oscsw_pkg::oscsw_state_t fsm;
    logic [3:0]           tick_cnt;
    logic [4:0]           osc_en;
    logic [15:0]          rdata;
    logic                 sw_pulse;
    logic [2:0]           core_log2;
    logic [3:0]           aux_log2;
    logic [9:0]           vco_mult;
  } oscsw_regs_t;

  oscsw_regs_t st_r;
  oscsw_regs_t st_nxt;

  // Oscillators a source needs running
  function automatic logic [4:0] oscsw_need(input logic [2:0] src);
    logic [4:0] n;
    n = '0;
    case (src)
      oscsw_pkg::SRC_FRC_PLL: begin
        n[oscsw_pkg::OSC_FRC] = 1'b1;
        n[oscsw_pkg::OSC_PLL] = 1'b1;
      end
      oscsw_pkg::SRC_PRI:     n[oscsw_pkg::OSC_PRI] = 1'b1;
      oscsw_pkg::SRC_PRI_PLL: begin
        n[oscsw_pkg::OSC_PRI] = 1'b1;
        n[oscsw_pkg::OSC_PLL] = 1'b1;
      end
      oscsw_pkg::SRC_SEC:     n[oscsw_pkg::OSC_SEC] = 1'b1;
      oscsw_pkg::SRC_LOW_POWER_INTERNAL_OSC:    n[oscsw_pkg::OSC_LOW_POWER_INTERNAL_OSC] = 1'b1;
      default:                n[oscsw_pkg::OSC_FRC] = 1'b1;
    endcase
    return n;
  endfunction

  logic       bus_req;
  logic       bus_wr;
  logic       ctl_wr;
  logic [4:0] need_new;
  logic       xtal_needed;
  logic       new_ready;

  assign bus_req = WB_CYC_I && WB_STB_I && !st_r.ack;
  assign bus_wr = bus_req && WB_WE_I;
  assign ctl_wr = bus_wr && (WB_ADR_I == oscsw_pkg::ADR_OSC_CONTROL) && st_r.armed;
  assign need_new = oscsw_need(st_r.req_src);
  // Crystal start-up applies to a crystal primary or the secondary crystal
  assign xtal_needed = (need_new[oscsw_pkg::OSC_PRI] &&
                        (PRIMARY_SUBMODE_CONFIG != oscsw_pkg::PRI_SUB_EXT)) ||
                       need_new[oscsw_pkg::OSC_SEC];
  assign new_ready = (!xtal_needed || CRYSTAL_STARTUP_DONE) &&
                     (!need_new[oscsw_pkg::OSC_PLL] || PLL_LOCKED);

  // Next-state logic for registers, unlock tracking and switch sequencer
  always_comb begin
    st_nxt = st_r;
    st_nxt.sw_pulse = 1'b0;
    st_nxt.ack = bus_req;
    // Bus writes
    if (bus_wr) begin
      st_nxt.key1_seen = 1'b0;
      st_nxt.armed = 1'b0;
      case (WB_ADR_I)
        oscsw_pkg::ADR_UNLOCK: begin
          st_nxt.key1_seen = (WB_DAT_I[15:0] == oscsw_pkg::UNLOCK_KEY1);
          st_nxt.armed = st_r.key1_seen && (WB_DAT_I[15:0] == oscsw_pkg::UNLOCK_KEY2);
        end
        oscsw_pkg::ADR_OSC_CONTROL: begin
          if (ctl_wr && WB_SEL_I[1]) begin
            st_nxt.req_src = WB_DAT_I[oscsw_pkg::REQ_LSB +: 3];
          end
          if (ctl_wr && WB_SEL_I[0]) begin
            st_nxt.sec_en = WB_DAT_I[oscsw_pkg::SECEN_BIT];
            if (!WB_DAT_I[oscsw_pkg::CF_BIT]) begin
              st_nxt.clk_fail = 1'b0;
            end
            if (WB_DAT_I[oscsw_pkg::SWREQ_BIT] && !SWITCHING_ENABLE_CONFIG) begin
              st_nxt.sw_req = 1'b1;
            end
          end
        end
        oscsw_pkg::ADR_CLOCK_DIVISOR: begin
          if (WB_SEL_I[1]) begin
            st_nxt.wake_full_speed_on_irq = WB_DAT_I[oscsw_pkg::ROI_BIT];
            st_nxt.doze = WB_DAT_I[oscsw_pkg::DOZE_LSB +: 3];
            st_nxt.core_slowdown_enable = WB_DAT_I[oscsw_pkg::CORE_SLOWDOWN_ENABLE_BIT];
            st_nxt.frc_post = WB_DAT_I[oscsw_pkg::FAST_RC_POSTSCALER_LSB +: 3];
          end
          if (WB_SEL_I[0]) begin
            st_nxt.vco_post = WB_DAT_I[oscsw_pkg::POST_LSB +: 2];
            st_nxt.pre_div = WB_DAT_I[oscsw_pkg::PRE_LSB +: 5];
          end
        end
        oscsw_pkg::ADR_PLL_FBD: begin
          if (WB_SEL_I[1]) begin
            st_nxt.fbd[8] = WB_DAT_I[8];
          end
          if (WB_SEL_I[0]) begin
            st_nxt.fbd[7:0] = WB_DAT_I[7:0];
          end
        end
        oscsw_pkg::ADR_TRIM: begin
          if (WB_SEL_I[0]) begin
            st_nxt.trim = WB_DAT_I[5:0];
          end
        end
        oscsw_pkg::ADR_AUX_CTRL: begin
          if (WB_SEL_I[1]) begin
            st_nxt.aux_src = WB_DAT_I[oscsw_pkg::AUX_DIVIDER_SOURCE_SEL_BIT];
            st_nxt.aux_mode = WB_DAT_I[oscsw_pkg::AOSC_LSB +: 2];
            st_nxt.aux_div = WB_DAT_I[oscsw_pkg::APST_LSB +: 3];
          end
          if (WB_SEL_I[0]) begin
            st_nxt.aux_ref = WB_DAT_I[oscsw_pkg::ASRC_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    // Interrupt returns the core to full speed
    if (st_r.wake_full_speed_on_irq && IRQ) begin
      st_nxt.core_slowdown_enable = 1'b0;
    end
    // Lock status follows the PLL while it runs
    st_nxt.lock = st_r.osc_en[oscsw_pkg::OSC_PLL] && PLL_LOCKED;
    // Boot source captured on the first enabled edge after reset
    if (!st_r.boot_done) begin
      st_nxt.boot_done = 1'b1;
      st_nxt.cur_src = POWER_ON_SOURCE_CONFIG;
      st_nxt.req_src = POWER_ON_SOURCE_CONFIG;
    end
    // Switch sequencer
    case (st_r.fsm)
      oscsw_pkg::SW_IDLE: begin
        if (st_r.sw_req && st_r.boot_done) begin
          st_nxt.fsm = oscsw_pkg::SW_CHECK;
        end
      end
      oscsw_pkg::SW_CHECK: begin
        if (st_r.req_src == st_r.cur_src) begin
          st_nxt.sw_req = 1'b0;
          st_nxt.fsm = oscsw_pkg::SW_IDLE;
        end else begin
          st_nxt.lock = 1'b0;
          st_nxt.clk_fail = 1'b0;
          st_nxt.fsm = oscsw_pkg::SW_WAIT;
        end
      end
      oscsw_pkg::SW_WAIT: begin
        st_nxt.tick_cnt = '0;
        if (new_ready) begin
          st_nxt.fsm = oscsw_pkg::SW_COUNT;
        end
      end
      oscsw_pkg::SW_COUNT: begin
        if (NEW_CLK_TICK) begin
          st_nxt.tick_cnt = st_r.tick_cnt + 4'h1;
          if (st_r.tick_cnt == oscsw_pkg::SETTLE_CYCLES - 4'h1) begin
            st_nxt.cur_src = st_r.req_src;
            st_nxt.sw_req = 1'b0;
            st_nxt.sw_pulse = 1'b1;
            st_nxt.fsm = oscsw_pkg::SW_IDLE;
          end
        end
      end
      default: st_nxt.fsm = oscsw_pkg::SW_IDLE;
    endcase
    // Hardware failure event wins over a clear in the same cycle
    if (CLOCK_FAIL_EVENT) begin
      st_nxt.clk_fail = 1'b1;
    end
    if (SWITCHING_ENABLE_CONFIG) begin
      st_nxt.sw_req = 1'b0;
    end
    // Running oscillators: current, new while switching, and kept ones
    st_nxt.osc_en = oscsw_need(st_nxt.cur_src);
    if (st_nxt.fsm != oscsw_pkg::SW_IDLE) begin
      st_nxt.osc_en = st_nxt.osc_en | oscsw_need(st_nxt.req_src);
    end
    st_nxt.osc_en[oscsw_pkg::OSC_SEC] = st_nxt.osc_en[oscsw_pkg::OSC_SEC] ||
                                        st_nxt.sec_en;
    st_nxt.osc_en[oscsw_pkg::OSC_LOW_POWER_INTERNAL_OSC] = st_nxt.osc_en[oscsw_pkg::OSC_LOW_POWER_INTERNAL_OSC] ||
                                         WDT_OR_MONITOR_EN;
    // Decoded divider outputs
    st_nxt.core_log2 = st_nxt.core_slowdown_enable ? st_nxt.doze : 3'h0;
    st_nxt.vco_mult = {1'b0, st_nxt.fbd} + oscsw_pkg::FBD_OFFSET;
    st_nxt.aux_log2 = (st_nxt.aux_div == oscsw_pkg::APST_DIV256) ? oscsw_pkg::AUX_LOG2_256 :
                      {1'b0, oscsw_pkg::APST_DIV1 - st_nxt.aux_div};
    // Read data, unmapped reads as zero
    st_nxt.rdata = '0;
    case (WB_ADR_I)
      oscsw_pkg::ADR_OSC_CONTROL: begin
        st_nxt.rdata[oscsw_pkg::CUR_LSB +: 3] = st_r.cur_src;
        st_nxt.rdata[oscsw_pkg::REQ_LSB +: 3] = st_r.req_src;
        st_nxt.rdata[oscsw_pkg::LOCK_BIT] = st_r.lock;
        st_nxt.rdata[oscsw_pkg::CF_BIT] = st_r.clk_fail;
        st_nxt.rdata[oscsw_pkg::SECEN_BIT] = st_r.sec_en;
        st_nxt.rdata[oscsw_pkg::SWREQ_BIT] = st_r.sw_req;
      end
      oscsw_pkg::ADR_CLOCK_DIVISOR: begin
        st_nxt.rdata = {st_r.wake_full_speed_on_irq, st_r.doze, st_r.core_slowdown_enable, st_r.frc_post, st_r.vco_post,
                        1'b0, st_r.pre_div};
      end
      oscsw_pkg::ADR_PLL_FBD:  st_nxt.rdata = {7'h00, st_r.fbd};
      oscsw_pkg::ADR_TRIM:     st_nxt.rdata = {10'h000, st_r.trim};
      oscsw_pkg::ADR_AUX_CTRL: begin
        st_nxt.rdata = {2'h0, st_r.aux_src, st_r.aux_mode, st_r.aux_div, st_r.aux_ref, 7'h00};
      end
      default: st_nxt.rdata = '0;
    endcase
    // Clock enable low freezes everything
    if (!CE) begin
      st_nxt = st_r;
    end
  end

  // State register
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r <= '0;
      st_r.fsm <= oscsw_pkg::SW_IDLE;
      st_r.wake_full_speed_on_irq <= oscsw_pkg::CLOCK_DIVISOR_RST[oscsw_pkg::ROI_BIT];
      st_r.doze <= oscsw_pkg::CLOCK_DIVISOR_RST[oscsw_pkg::DOZE_LSB +: 3];
      st_r.vco_post <= oscsw_pkg::CLOCK_DIVISOR_RST[oscsw_pkg::POST_LSB +: 2];
      st_r.fbd <= oscsw_pkg::PLL_FBD_RST;
      st_r.vco_mult <= {1'b0, oscsw_pkg::PLL_FBD_RST} + oscsw_pkg::FBD_OFFSET;
      st_r.aux_log2 <= oscsw_pkg::AUX_LOG2_256;
      st_r.osc_en <= 5'h01;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign WB_ACK_O = st_r.ack;
  assign WB_DAT_O = {16'h0000, st_r.rdata};
  assign OSC_ENABLE = st_r.osc_en;
  assign CURRENT_SOURCE_SEL = st_r.cur_src;
  assign SWITCH_NOW = st_r.sw_pulse;
  assign CORE_RATIO_LOG2 = st_r.core_log2;
  assign FAST_RC_POSTSCALER = st_r.frc_post;
  assign VCO_OUTPUT_DIVIDER = st_r.vco_post;
  assign PHASE_DETECTOR_INPUT_DIVIDER = st_r.pre_div;
  assign VCO_MULTIPLIER = st_r.vco_mult;
  assign FAST_OSC_TRIM = st_r.trim;
  assign AUX_OSC_MODE = st_r.aux_mode;
  assign AUX_DIVIDE_LOG2 = st_r.aux_log2;
  assign AUX_REFERENCE_SEL = st_r.aux_ref;
  assign AUX_DIVIDER_SOURCE_SEL = st_r.aux_src;

  // Checks on the sequencer and registers
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N || !CE);

  abort_equal_a: assert property (
    st_r.fsm == oscsw_pkg::SW_CHECK && st_r.req_src == st_r.cur_src && CE
    |=> !st_r.sw_req && st_r.fsm == oscsw_pkg::SW_IDLE) else $error("equal switch not aborted");
  clear_status_a: assert property (
    st_r.fsm == oscsw_pkg::SW_CHECK && st_r.req_src != st_r.cur_src && !CLOCK_FAIL_EVENT
    |=> !st_r.lock && !st_r.clk_fail) else $error("status not cleared at switch start");
  switch_done_a: assert property (
    st_r.fsm == oscsw_pkg::SW_COUNT && NEW_CLK_TICK &&
    st_r.tick_cnt == oscsw_pkg::SETTLE_CYCLES - 4'h1
    |=> st_r.cur_src == $past(st_r.req_src) && !st_r.sw_req && SWITCH_NOW)
    else $error("switch not finished after ten ticks");
  wait_ready_a: assert property (
    st_r.fsm == oscsw_pkg::SW_WAIT && !new_ready |=> st_r.fsm == oscsw_pkg::SW_WAIT)
    else $error("left wait before source ready");
  req_held_a: assert property (
    st_r.sw_req && st_r.fsm == oscsw_pkg::SW_WAIT && !SWITCHING_ENABLE_CONFIG |=> st_r.sw_req)
    else $error("switch request dropped early");
  sw_disabled_a: assert property (
    SWITCHING_ENABLE_CONFIG |=> !st_r.sw_req) else $error("request set while disabled");
  wake_full_a: assert property (
    st_r.wake_full_speed_on_irq && IRQ |=> !st_r.core_slowdown_enable ##1 CORE_RATIO_LOG2 == 3'h0)
    else $error("interrupt did not restore full speed");
  locked_write_a: assert property (
    bus_wr && WB_ADR_I == oscsw_pkg::ADR_OSC_CONTROL && !st_r.armed
    |=> $stable(st_r.sec_en) && $stable(st_r.req_src)) else $error("locked write took effect");
  ratio_one_a: assert property (
    !st_r.core_slowdown_enable |-> CORE_RATIO_LOG2 == 3'h0) else $error("ratio not forced to one");
  ack_pulse_a: assert property (
    WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");

endmodule // oscsw_top

// File: verification/oscsw_top_tb.sv
// Self-checking testbench for the oscillator control and clock-switch block
`timescale 1ns/1ps
module oscsw_top_tb;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic        sw_cfg = 1'b0, wdt_en = 1'b0, pll_lk = 1'b0, xtal_ok = 1'b0;
  logic [2:0]  por_src = 3'h0;
  logic [1:0]  pri_sub = 2'h1;
  logic        tick = 1'b0, cfail = 1'b0, irq = 1'b0;
  logic        ce = 1'b1;
  wire logic [31:0] dat_o;
  wire logic        ack, sw_now, aref, asrc;
  wire logic [4:0]  osc_en, pre;
  wire logic [2:0]  cur, ratio, fast_rc_postscaler;
  wire logic [1:0]  post, amode;
  wire logic [9:0]  mult;
  wire logic [5:0]  trim;
  wire logic [3:0]  alog;
  int          errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  logic [31:0] q;

  // Design under test
  oscsw_top dut_u (.CLK(clk), .ARST_N(arst_n), .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .SWITCHING_ENABLE_CONFIG(sw_cfg), .POWER_ON_SOURCE_CONFIG(por_src),
    .PRIMARY_SUBMODE_CONFIG(pri_sub), .WDT_OR_MONITOR_EN(wdt_en), .PLL_LOCKED(pll_lk),
    .CRYSTAL_STARTUP_DONE(xtal_ok), .NEW_CLK_TICK(tick), .CLOCK_FAIL_EVENT(cfail),
    .IRQ(irq), .OSC_ENABLE(osc_en), .CURRENT_SOURCE_SEL(cur), .SWITCH_NOW(sw_now),
    .CORE_RATIO_LOG2(ratio), .FAST_RC_POSTSCALER(fast_rc_postscaler), .VCO_OUTPUT_DIVIDER(post),
    .PHASE_DETECTOR_INPUT_DIVIDER(pre), .VCO_MULTIPLIER(mult), .FAST_OSC_TRIM(trim),
    .AUX_OSC_MODE(amode), .AUX_DIVIDE_LOG2(alog), .AUX_REFERENCE_SEL(aref),
    .AUX_DIVIDER_SOURCE_SEL(asrc));

  // Clock and hang guard
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= {16'h0000, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_o;
    chk("bus ack", 32'h1, {31'h0, ack});
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [15:0] d);
    wb(1'b1, a, s, d);
  endtask

  task automatic rd(input logic [7:0] a, input string name, input logic [15:0] exp);
    wb(1'b0, a, 4'h3, 16'h0000);
    chk(name, {16'h0000, exp}, q);
  endtask

  // Unlock pair followed at once by a control write
  task automatic ctl(input logic [3:0] s, input logic [15:0] d);
    wr(oscsw_pkg::ADR_UNLOCK, 4'h3, oscsw_pkg::UNLOCK_KEY1);
    wr(oscsw_pkg::ADR_UNLOCK, 4'h3, oscsw_pkg::UNLOCK_KEY2);
    wr(oscsw_pkg::ADR_OSC_CONTROL, s, d);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
    #1;
  endtask

  task automatic t_reset();
    chk("osc enable", 32'h01, {27'h0, osc_en});
    chk("multiplier", 32'h32, {22'h0, mult});
    chk("aux log2", 32'h8, {28'h0, alog});
    chk("vco div", 32'h1, {30'h0, post});
    rd(oscsw_pkg::ADR_OSC_CONTROL, "control", 16'h0000);
    rd(oscsw_pkg::ADR_CLOCK_DIVISOR, "divisor", 16'h3040);
    rd(oscsw_pkg::ADR_PLL_FBD, "feedback", 16'h0030);
    rd(oscsw_pkg::ADR_AUX_CTRL, "aux", 16'h0000);
  endtask

  // Writes without a fresh unlock, or with a write between, are dropped
  task automatic t_unlock();
    wr(oscsw_pkg::ADR_OSC_CONTROL, 4'h2, 16'h0200);
    rd(oscsw_pkg::ADR_OSC_CONTROL, "no unlock", 16'h0000);
    wr(oscsw_pkg::ADR_UNLOCK, 4'h3, oscsw_pkg::UNLOCK_KEY1);
    wr(oscsw_pkg::ADR_UNLOCK, 4'h3, oscsw_pkg::UNLOCK_KEY2);
    wr(oscsw_pkg::ADR_TRIM, 4'h3, 16'h0000);
    wr(oscsw_pkg::ADR_OSC_CONTROL, 4'h2, 16'h0200);
    rd(oscsw_pkg::ADR_OSC_CONTROL, "stale unlock", 16'h0000);
    ctl(4'h2, 16'h0200);
    rd(oscsw_pkg::ADR_OSC_CONTROL, "requested", 16'h0200);
  endtask

  // Switch to crystal primary: waits for start-up, then ten new clocks
  task automatic t_switch_pri();
    ctl(4'h1, 16'h0001);
    rd(oscsw_pkg::ADR_OSC_CONTROL, "request held", 16'h0201);
    chk("primary on", 32'h1, {31'h0, osc_en[oscsw_pkg::OSC_PRI]});
    ticks(12);
    rd(oscsw_pkg::ADR_OSC_CONTROL, "crystal wait", 16'h0201);
    xtal_ok <= 1'b1;
    repeat (4) @(posedge clk);
    ticks(9);
    chk("before tenth", 32'h0, {29'h0, cur});
    ticks(1);
    chk("switch pulse", 32'h1, {31'h0, sw_now});
    chk("current", 32'h2, {29'h0, cur});
    rd(oscsw_pkg::ADR_OSC_CONTROL, "after switch", 16'h2200);
    chk("old stopped", 32'h02, {27'h0, osc_en});
  endtask

  task automatic t_abort();
    ctl(4'h1, 16'h0001);
    repeat (4) @(posedge clk);
    rd(oscsw_pkg::ADR_OSC_CONTROL, "equal abort", 16'h2200);
  endtask

  // Failure flag set, then cleared as a PLL switch begins
  task automatic t_pll();
    pll_lk <= 1'b1;
    @(posedge clk);
    cfail <= 1'b1;
    @(posedge clk);
    cfail <= 1'b0;
    rd(oscsw_pkg::ADR_OSC_CONTROL, "fail flag", 16'h2208);
    ctl(4'h2, 16'h0100);
    ctl(4'h1, 16'h0009);
    repeat (4) @(posedge clk);
    chk("pll on", 32'h1, {31'h0, osc_en[oscsw_pkg::OSC_PLL]});
    ticks(10);
    rd(oscsw_pkg::ADR_OSC_CONTROL, "pll switch", 16'h1120);
    chk("pll sources", 32'h11, {27'h0, osc_en});
    ctl(4'h1, 16'h0002);
    chk("secondary on", 32'h1, {31'h0, osc_en[oscsw_pkg::OSC_SEC]});
    ctl(4'h1, 16'h0000);
    chk("secondary off", 32'h0, {31'h0, osc_en[oscsw_pkg::OSC_SEC]});
    wdt_en <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("low_power_internal_osc kept", 32'h1, {31'h0, osc_en[oscsw_pkg::OSC_LOW_POWER_INTERNAL_OSC]});
  endtask

  task automatic t_div();
    for (int c = 0; c < 8; c++) begin
      wr(oscsw_pkg::ADR_CLOCK_DIVISOR, 4'h3, {1'b0, 3'(c), 12'h840});
      chk("core ratio", 32'(c), {29'h0, ratio});
    end
    wr(oscsw_pkg::ADR_CLOCK_DIVISOR, 4'h3, 16'h37ff);
    chk("ratio forced", 32'h0, {29'h0, ratio});
    chk("rc post", 32'h7, {29'h0, fast_rc_postscaler});
    chk("vco post", 32'h3, {30'h0, post});
    chk("pre div", 32'h1f, {27'h0, pre});
    rd(oscsw_pkg::ADR_CLOCK_DIVISOR, "divisor rw", 16'h37df);
    wr(oscsw_pkg::ADR_CLOCK_DIVISOR, 4'h3, 16'hb840);
    irq <= 1'b1;
    repeat (3) @(posedge clk);
    irq <= 1'b0;
    #1;
    chk("wake ratio", 32'h0, {29'h0, ratio});
    rd(oscsw_pkg::ADR_CLOCK_DIVISOR, "wake clear", 16'hb040);
    wr(oscsw_pkg::ADR_CLOCK_DIVISOR, 4'h3, 16'h3840);
    irq <= 1'b1;
    repeat (3) @(posedge clk);
    irq <= 1'b0;
    #1;
    chk("irq ignored", 32'h3, {29'h0, ratio});
  endtask

  // Clock enable low first: a failure event while frozen is not seen
  task automatic t_misc();
    @(posedge clk);
    ce <= 1'b0;
    cfail <= 1'b1;
    @(posedge clk);
    cfail <= 1'b0;
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    rd(oscsw_pkg::ADR_OSC_CONTROL, "frozen flag", 16'h1120);
    wr(oscsw_pkg::ADR_PLL_FBD, 4'h3, 16'h001e);
    chk("mult 32", 32'h20, {22'h0, mult});
    wr(oscsw_pkg::ADR_PLL_FBD, 4'h3, 16'hffff);
    chk("mult max", 32'h201, {22'h0, mult});
    rd(oscsw_pkg::ADR_PLL_FBD, "feedback rw", 16'h01ff);
    wr(oscsw_pkg::ADR_TRIM, 4'h3, 16'hffff);
    chk("trim", 32'h3f, {26'h0, trim});
    rd(oscsw_pkg::ADR_TRIM, "trim rw", 16'h003f);
    for (int c = 0; c < 8; c++) begin
      wr(oscsw_pkg::ADR_AUX_CTRL, 4'h3, {5'h1f, 3'(c), 8'hff});
      chk("aux div", (c == 0) ? 32'h8 : 32'(7 - c), {28'h0, alog});
    end
    chk("aux mode", 32'h3, {30'h0, amode});
    chk("aux sels", 32'h3, {30'h0, aref, asrc});
    rd(oscsw_pkg::ADR_AUX_CTRL, "aux rw", 16'h3f80);
    wr(8'h18, 4'h3, 16'hffff);
    rd(8'h18, "unmapped", 16'h0000);
  endtask

  // Switching disabled: boot source reported, request bit stays low
  task automatic t_locked();
    sw_cfg <= 1'b1;
    por_src <= oscsw_pkg::SRC_LOW_POWER_INTERNAL_OSC;
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("boot source", 32'h5, {29'h0, cur});
    ctl(4'h1, 16'h0001);
    repeat (4) @(posedge clk);
    rd(oscsw_pkg::ADR_OSC_CONTROL, "switch off", 16'h5500);
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    t_reset();
    t_unlock();
    t_switch_pri();
    t_abort();
    t_pll();
    t_div();
    t_misc();
    t_locked();
    stop_test();
  end
endmodule // oscsw_top_tb
